// ### hdl/srp_pkg.sv
// constants, types and helper functions shared by the region-protect command block
//------------------------------------------------------------------------------
// Overview of operation
// - config read opcode 2bh, one dummy clock, then 16-bit config, low byte first
// - every read-out bit or nibble is driven on the falling serial clock edge
// - continued clocking after config read repeats the 16-bit value every 16 bits
// - config program 2fh is accepted only while the write latch is set
// - config program runs only if chip select rises right after data bit 16
// - valid program frame end starts timed operation; busy is 1 throughout, then 0 on success or after a status clear on failure
// - finishing a config, freeze or secret program clears the write latch
// - config program drives busy and program error like an array program
// - lock state read a7h, one dummy clock, 8-bit register, repeats every 8
// - freeze a6h clears lock bit 0 and copies config bit 6 to lock bit 6
// - freeze is accepted only while the write latch is set
// - freeze runs only if chip select rises right after opcode bit 8
// - with config bit 2 at 0 the secret read returns filler, not the secret
// - secret read e7h, one dummy clock, 64 bits low byte first, repeats every 64
// - secret program e8h is accepted only while the write latch is set
// - with config bit 2 at 0 every secret program is ignored
// - secret program carries 64 bits, low byte first; chip select after bit 64
// - a failed secret program sets the program error flag
// - in quad command mode all phases move four bits per clock on io0-io3
// - status flags stay readable while a timed operation runs
// - opcode-only commands run only if chip select rises after opcode bit 8
//------------------------------------------------------------------------------
package srp_pkg;

   // command opcodes
   localparam logic [7:0] SRP_OP_CFG_RD      = 8'h2b;
   localparam logic [7:0] SRP_OP_CFG_WR      = 8'h2f;
   localparam logic [7:0] SRP_OP_LOCK_RD     = 8'ha7;
   localparam logic [7:0] SRP_OP_LOCK_FRZ    = 8'ha6;
   localparam logic [7:0] SRP_OP_SEC_RD      = 8'he7;
   localparam logic [7:0] SRP_OP_SEC_WR      = 8'he8;
   localparam logic [7:0] SRP_OP_UNLOCK_DFLT = 8'h06;

   // frame lengths in bits, opcode included
   localparam logic [6:0] SRP_OP_BITS     = 7'h08;
   localparam logic [6:0] SRP_CFG_WR_BITS = 7'h18;
   localparam logic [6:0] SRP_SEC_WR_BITS = 7'h48;
   localparam logic [6:0] SRP_BITS_MAX    = 7'h7f;

   // read-out wrap masks (length minus one)
   localparam logic [5:0] SRP_CFG_WRAP  = 6'h0f;
   localparam logic [5:0] SRP_LOCK_WRAP = 6'h07;
   localparam logic [5:0] SRP_SEC_WRAP  = 6'h3f;

   // field positions
   localparam int SRP_LOCK_VOL_POS    = 0;
   localparam int SRP_LOCK_SECURE_POS = 6;
   localparam int SRP_CFG_SECURE_POS  = 6;
   localparam int SRP_CFG_PWMODE_POS  = 2;

   // reset values and the filler for hidden secret reads
   localparam logic [15:0] SRP_CFG_RST    = 16'hffff;
   localparam logic [7:0]  SRP_LOCK_RST   = 8'h01;
   localparam logic [63:0] SRP_SEC_RST    = 64'hffff_ffff_ffff_ffff;
   localparam logic [63:0] SRP_SEC_HIDDEN = 64'hffff_ffff_ffff_ffff;

   // timed operation length in clk cycles
   localparam int SRP_PROG_CYCLES_DFLT = 200;

   typedef enum logic [2:0] {
      SRP_ST_IDLE = 3'b001,
      SRP_ST_BUSY = 3'b010,
      SRP_ST_HALT = 3'b100
   } srp_state_e;

   typedef enum logic [2:0] {
      SRP_JOB_CFG = 3'b001,
      SRP_JOB_FRZ = 3'b010,
      SRP_JOB_SEC = 3'b100
   } srp_job_e;

   // what one frame left behind in the link domain
   typedef struct packed {
      logic [6:0]  bits;
      logic [63:0] data;
      logic [7:0]  op;
   } srp_frame_s;

   typedef struct packed {
      srp_frame_s  frame;
      logic        rd_active;
      logic [5:0]  rdpos;
      logic        tog;
   } srp_rx_s;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] oe;
   } srp_tx_s;

   typedef struct packed {
      srp_state_e  state;
      srp_job_e    job;
      logic [15:0] cnt;
      logic        cs_q;
      logic        tog_seen;
      logic        latch;
      logic        busy;
      logic        err;
      logic [15:0] cfg;
      logic [7:0]  lock;
      logic [63:0] sec;
      logic [63:0] data;
   } srp_eng_s;

   function automatic logic [63:0] srp_byte_rev64(input logic [63:0] v);
      logic [63:0] r;
      r = '0;
      for (int i = 0; i < 8; i++) begin
         r[8*i +: 8] = v[8*(7-i) +: 8];
      end
      return r;
   endfunction

endpackage

// ### hdl/srp_sync.sv
// two-flop synchroniser for a group of levels
`timescale 1ns/1ps
module srp_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } srp_sync_s;

   srp_sync_s st;
   srp_sync_s next_st;

   // first stage feeds only the second
   always_comb begin
      next_st.s1 = d;
      next_st.s2 = st.s1;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= {RST_VAL, RST_VAL};
      end else begin
         st <= next_st;
      end
   end

   assign q = st.s2;

endmodule

// ### hdl/srp_tx.sv
// falling-edge output driver for read-out data on io0-io3
`timescale 1ns/1ps
module srp_tx (
   input  wire logic        sclk,
   input  wire logic        clr,
   input  wire logic        active,
   input  wire logic        quad,
   input  wire logic [63:0] vec,
   input  wire logic [5:0]  pos,
   output logic      [3:0]  io_out,
   output logic      [3:0]  io_oe
);

   srp_pkg::srp_tx_s st;
   srp_pkg::srp_tx_s next_st;
   logic [63:0]      shifted;

   always_comb begin
      shifted = vec << pos;
      next_st = '0;
      if (active) begin
         if (quad) begin
            next_st.out = shifted[63:60];
            next_st.oe  = 4'hf;
         end else begin
            next_st.out = {2'h0, shifted[63], 1'h0};
            next_st.oe  = 4'h2;
         end
      end
   end

   // lines float at frame end and during the dummy clock
   always_ff @(negedge sclk or posedge clr) begin
      if (clr) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign io_out = st.out;
   assign io_oe  = st.oe;

endmodule

// ### hdl/srp_region_protect.sv
// serial flash protection-configuration command handler with timed program engine
`timescale 1ns/1ps
module srp_region_protect #(
   parameter int          PROG_CYCLES = srp_pkg::SRP_PROG_CYCLES_DFLT,
   parameter logic [7:0]  UNLOCK_OP   = srp_pkg::SRP_OP_UNLOCK_DFLT,
   parameter logic [15:0] CFG_RST     = srp_pkg::SRP_CFG_RST,
   parameter logic [7:0]  LOCK_RST    = srp_pkg::SRP_LOCK_RST,
   parameter logic [63:0] SEC_RST     = srp_pkg::SRP_SEC_RST
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic [3:0]  io_in,
   output logic      [3:0]  io_out,
   output logic      [3:0]  io_oe,
   input  wire logic        quad_cmd_mode,
   input  wire logic        prog_fail,
   input  wire logic        status_clear,
   output logic             busy_flag,
   output logic             write_latch,
   output logic             prog_err,
   output logic      [15:0] sector_guard_cfg,
   output logic      [7:0]  lock_state_reg
);

   //---------------------------------------------------------------------------
   // reset and synchronisers
   //---------------------------------------------------------------------------
   logic rst_n;
   logic quad_l;
   logic cs_s;
   logic tog_s;
   logic fail_s;
   logic clr_s;
   logic tx_clr;

   // reset asserts at once and releases two clk edges later
   srp_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b0)
   ) rst_sync_u (
      .clk   (clk),
      .rst_n (resetn),
      .d     (1'b1),
      .q     (rst_n)
   );

   // mode changes only between frames, so the link side may read this copy
   srp_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b0)
   ) quad_sync_u (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (quad_cmd_mode),
      .q     (quad_l)
   );

   // idles high so that reset does not fake a frame end
   srp_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b1)
   ) cs_sync_u (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (cs_n),
      .q     (cs_s)
   );

   // frame toggle from the link domain
   srp_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b0)
   ) tog_sync_u (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (rx.tog),
      .q     (tog_s)
   );

   srp_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b0)
   ) fail_sync_u (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (prog_fail),
      .q     (fail_s)
   );

   srp_sync #(
      .WIDTH   (1),
      .RST_VAL (1'b0)
   ) clr_sync_u (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (status_clear),
      .q     (clr_s)
   );

   //---------------------------------------------------------------------------
   // timed program engine state
   //---------------------------------------------------------------------------
   localparam logic [15:0] LAST_CNT = 16'(PROG_CYCLES - 1);
   localparam srp_pkg::srp_eng_s ENG_RST = '{
      state    : srp_pkg::SRP_ST_IDLE,
      job      : srp_pkg::SRP_JOB_CFG,
      cnt      : 16'h0000,
      cs_q     : 1'b1,
      tog_seen : 1'b0,
      latch    : 1'b0,
      busy     : 1'b0,
      err      : 1'b0,
      cfg      : CFG_RST,
      lock     : LOCK_RST,
      sec      : SEC_RST,
      data     : 64'h0
   };

   srp_pkg::srp_eng_s eng;
   srp_pkg::srp_eng_s next_eng;
   logic              frame_end;
   logic              pw_mode;

   //---------------------------------------------------------------------------
   // link domain: frame capture on rising sclk
   //---------------------------------------------------------------------------
   srp_pkg::srp_rx_s rx;
   srp_pkg::srp_rx_s next_rx;
   logic             fresh;
   logic             op_is_rd;
   logic [6:0]       bits_now;
   logic [6:0]       bit_step;
   logic [5:0]       pos_step;
   logic [5:0]       wrap;
   logic [63:0]      rd_vec;

   // set while deselected, so the first edge of a frame restarts the count
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fresh <= 1'b1;
      end else begin
         fresh <= 1'b0;
      end
   end

   always_comb begin
      op_is_rd = 1'b1;
      wrap     = srp_pkg::SRP_CFG_WRAP;
      case (rx.frame.op)
         srp_pkg::SRP_OP_CFG_RD: begin
            wrap = srp_pkg::SRP_CFG_WRAP;
         end
         srp_pkg::SRP_OP_LOCK_RD: begin
            wrap = srp_pkg::SRP_LOCK_WRAP;
         end
         srp_pkg::SRP_OP_SEC_RD: begin
            wrap = srp_pkg::SRP_SEC_WRAP;
         end
         default: begin
            op_is_rd = 1'b0;
         end
      endcase
   end

   always_comb begin
      bit_step = quad_l ? 7'h04 : 7'h01;
      pos_step = quad_l ? 6'h04 : 6'h01;
      bits_now = fresh ? 7'h00 : rx.frame.bits;
      next_rx  = rx;
      if (fresh) begin
         next_rx.tog       = ~rx.tog;
         next_rx.rd_active = 1'b0;
      end
      // opcode first, then everything else into the data shifter
      if (bits_now < srp_pkg::SRP_OP_BITS) begin
         if (quad_l) begin
            next_rx.frame.op = {rx.frame.op[3:0], io_in};
         end else begin
            next_rx.frame.op = {rx.frame.op[6:0], io_in[0]};
         end
      end else begin
         if (quad_l) begin
            next_rx.frame.data = {rx.frame.data[59:0], io_in};
         end else begin
            next_rx.frame.data = {rx.frame.data[62:0], io_in[0]};
         end
      end
      // saturate well above the longest frame so overlong frames never match
      if (bits_now < (srp_pkg::SRP_BITS_MAX - 7'h04)) begin
         next_rx.frame.bits = bits_now + bit_step;
      end else begin
         next_rx.frame.bits = bits_now;
      end
      // edge after the opcode is the dummy clock; first bit leaves on its fall
      if (bits_now == srp_pkg::SRP_OP_BITS && op_is_rd) begin
         next_rx.rd_active = 1'b1;
         next_rx.rdpos     = 6'h00;
      end else if (rx.rd_active && !fresh) begin
         next_rx.rdpos = (rx.rdpos + pos_step) & wrap;
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         rx <= '0;
      end else begin
         rx <= next_rx;
      end
   end

   //---------------------------------------------------------------------------
   // read-out vector, transmit order from the top bit down
   //---------------------------------------------------------------------------
   // registers change only while no frame runs, so the link side reads them
   // without a handshake; a read during a timed operation may tear
   assign pw_mode = ~eng.cfg[srp_pkg::SRP_CFG_PWMODE_POS];

   always_comb begin
      rd_vec = '0;
      case (rx.frame.op)
         srp_pkg::SRP_OP_CFG_RD: begin
            rd_vec = {eng.cfg[7:0], eng.cfg[15:8], 48'h0};
         end
         srp_pkg::SRP_OP_LOCK_RD: begin
            rd_vec = {eng.lock, 56'h0};
         end
         srp_pkg::SRP_OP_SEC_RD: begin
            if (pw_mode) begin
               rd_vec = srp_pkg::SRP_SEC_HIDDEN;
            end else begin
               rd_vec = srp_pkg::srp_byte_rev64(eng.sec);
            end
         end
         default: begin
            rd_vec = '0;
         end
      endcase
   end

   assign tx_clr = cs_n | ~rst_n;

   srp_tx tx_u (
      .sclk   (sclk),
      .clr    (tx_clr),
      .active (rx.rd_active),
      .quad   (quad_l),
      .vec    (rd_vec),
      .pos    (rx.rdpos),
      .io_out (io_out),
      .io_oe  (io_oe)
   );

   //---------------------------------------------------------------------------
   // timed program engine, clk domain
   //---------------------------------------------------------------------------
   // frame fields are read two clk edges after chip select rose, when the
   // link clock has stopped and they hold still
   always_comb begin
      frame_end     = cs_s && !eng.cs_q && (tog_s != eng.tog_seen);
      next_eng      = eng;
      next_eng.cs_q = cs_s;
      if (frame_end) begin
         next_eng.tog_seen = tog_s;
      end
      unique case (eng.state)
         srp_pkg::SRP_ST_IDLE: begin
            if (clr_s) begin
               next_eng.err = 1'b0;
            end
            if (frame_end) begin
               if (rx.frame.op == UNLOCK_OP && rx.frame.bits == srp_pkg::SRP_OP_BITS) begin
                  next_eng.latch = 1'b1;
               end else if (rx.frame.op == srp_pkg::SRP_OP_CFG_WR && eng.latch
                            && rx.frame.bits == srp_pkg::SRP_CFG_WR_BITS) begin
                  next_eng.state = srp_pkg::SRP_ST_BUSY;
                  next_eng.job   = srp_pkg::SRP_JOB_CFG;
                  next_eng.busy  = 1'b1;
                  next_eng.cnt   = 16'h0000;
                  next_eng.data  = rx.frame.data;
               end else if (rx.frame.op == srp_pkg::SRP_OP_LOCK_FRZ && eng.latch
                            && rx.frame.bits == srp_pkg::SRP_OP_BITS) begin
                  next_eng.state = srp_pkg::SRP_ST_BUSY;
                  next_eng.job   = srp_pkg::SRP_JOB_FRZ;
                  next_eng.busy  = 1'b1;
                  next_eng.cnt   = 16'h0000;
                  next_eng.data  = rx.frame.data;
               end else if (rx.frame.op == srp_pkg::SRP_OP_SEC_WR && eng.latch && !pw_mode
                            && rx.frame.bits == srp_pkg::SRP_SEC_WR_BITS) begin
                  next_eng.state = srp_pkg::SRP_ST_BUSY;
                  next_eng.job   = srp_pkg::SRP_JOB_SEC;
                  next_eng.busy  = 1'b1;
                  next_eng.cnt   = 16'h0000;
                  next_eng.data  = rx.frame.data;
               end
            end
         end
         srp_pkg::SRP_ST_BUSY: begin
            next_eng.cnt = eng.cnt + 16'h0001;
            if (eng.cnt == LAST_CNT) begin
               next_eng.latch = 1'b0;
               if (fail_s) begin
                  // busy stays up until the status is cleared
                  next_eng.state = srp_pkg::SRP_ST_HALT;
                  next_eng.err   = 1'b1;
               end else begin
                  next_eng.state = srp_pkg::SRP_ST_IDLE;
                  next_eng.busy  = 1'b0;
                  unique case (eng.job)
                     srp_pkg::SRP_JOB_CFG: begin
                        next_eng.cfg = {eng.data[7:0], eng.data[15:8]};
                     end
                     srp_pkg::SRP_JOB_FRZ: begin
                        next_eng.lock[srp_pkg::SRP_LOCK_VOL_POS] = 1'b0;
                        next_eng.lock[srp_pkg::SRP_LOCK_SECURE_POS] = eng.cfg[srp_pkg::SRP_CFG_SECURE_POS];
                     end
                     srp_pkg::SRP_JOB_SEC: begin
                        next_eng.sec = srp_pkg::srp_byte_rev64(eng.data);
                     end
                  endcase
               end
            end
         end
         srp_pkg::SRP_ST_HALT: begin
            if (clr_s) begin
               next_eng.state = srp_pkg::SRP_ST_IDLE;
               next_eng.busy  = 1'b0;
               next_eng.err   = 1'b0;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eng <= ENG_RST;
      end else begin
         eng <= next_eng;
      end
   end

   //---------------------------------------------------------------------------
   // outputs
   //---------------------------------------------------------------------------
   // status flags stay readable while a timed operation runs
   assign busy_flag        = eng.busy;
   assign write_latch      = eng.latch;
   assign prog_err         = eng.err;
   assign sector_guard_cfg = eng.cfg;
   assign lock_state_reg   = eng.lock;

endmodule

// ### tb/srp_checker.sv
// port assertions for the region-protect command block
`timescale 1ns/1ps
module srp_checker (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        cs_n,
   input wire logic        quad_cmd_mode,
   input wire logic        prog_fail,
   input wire logic [3:0]  io_oe,
   input wire logic        busy_flag,
   input wire logic        write_latch,
   input wire logic        prog_err,
   input wire logic [15:0] sector_guard_cfg,
   input wire logic [7:0]  lock_state_reg
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!resetn);
   sequence op_start;
      $rose(busy_flag);
   endsequence
   chk_start_latched: assert property (op_start |-> write_latch)
      else $error("timed op started without write latch");
   chk_busy_hold: assert property (op_start |-> busy_flag[*8])
      else $error("busy dropped early");
   chk_busy_end: assert property (op_start and !prog_fail |-> ##[8:300] !busy_flag)
      else $error("busy never ended");
   chk_latch_clear: assert property ($fell(busy_flag) |-> ##[0:2] !write_latch)
      else $error("latch kept after op");
   chk_cfg_quiet: assert property (!$stable(sector_guard_cfg) |-> busy_flag || $past(busy_flag))
      else $error("config changed outside op");
   chk_lock_quiet: assert property (!$stable(lock_state_reg) |-> busy_flag || $past(busy_flag))
      else $error("lock state changed outside op");
   chk_err_cause: assert property ($rose(prog_err) |-> prog_fail)
      else $error("program error without failure");
   chk_idle_oe: assert property (cs_n[*4] |-> io_oe == 4'h0)
      else $error("lines driven while deselected");
   chk_oe_width: assert property (io_oe != 4'h0 |-> io_oe == (quad_cmd_mode ? 4'hf : 4'h2))
      else $error("wrong lines driven");
endmodule
bind srp_region_protect srp_checker chk_u (.clk(clk), .resetn(resetn), .cs_n(cs_n),
   .quad_cmd_mode(quad_cmd_mode), .prog_fail(prog_fail), .io_oe(io_oe), .busy_flag(busy_flag),
   .write_latch(write_latch), .prog_err(prog_err), .sector_guard_cfg(sector_guard_cfg),
   .lock_state_reg(lock_state_reg));

// ### tb/srp_host.sv
// behavioural serial host, clock mode 0, clock idle between frames
`timescale 1ns/1ps
module srp_host (
   output logic       sclk,
   output logic       cs_n,
   output logic [3:0] io_in,
   input  wire logic [3:0] io_out
);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      io_in = 4'h5;
   end
   // released lines toggle so a stale value is never mistaken for data
   task automatic xfer(input logic q, input logic [71:0] t, input int nt, nr, output logic [63:0] rx);
      rx = '0;
      cs_n = 1'b0;
      for (int i = 0; i < nt; i += (q ? 4 : 1)) begin
         io_in = q ? t[71-i -: 4] : {~io_in[3:1], t[71-i]};
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
      if (nr > 0) begin
         io_in = ~io_in;
         #80 sclk = 1'b1;
         #80 sclk = 1'b0;
      end
      for (int i = 0; i < nr; i += (q ? 4 : 1)) begin
         #80 sclk = 1'b1;
         rx = q ? {rx[59:0], io_out} : {rx[62:0], io_out[1]};
         #80 sclk = 1'b0;
      end
      #80 cs_n = 1'b1;
      io_in = ~io_in;
      #320;
   endtask
endmodule

// ### tb/srp_region_protect_tb.sv
// self-checking bench for the region-protect command block
`timescale 1ns/1ps
module srp_region_protect_tb;
   logic        clk = 1'b0, resetn = 1'b0, pf = 1'b0, sc = 1'b0, q = 1'b0;
   wire         sclk, cs_n, busy, wl, pe;
   wire  [3:0]  io_in, io_out, io_oe;
   wire  [15:0] cfg;
   wire  [7:0]  lk;
   logic [63:0] rx;
   int          n_mismatch = 0, tests_run = 0, cyc = 0;
   localparam logic [71:0] UNL = {srp_pkg::SRP_OP_UNLOCK_DFLT, 64'h0};
   always #50 clk = ~clk;
   srp_host h (.sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out));
   srp_region_protect #(.PROG_CYCLES(20)) dut_u (.clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_cmd_mode(q), .prog_fail(pf), .status_clear(sc),
      .busy_flag(busy), .write_latch(wl), .prog_err(pe), .sector_guard_cfg(cfg), .lock_state_reg(lk));
   task chk(input logic [63:0] s, e);
      tests_run++;
      if (s !== e) begin
         n_mismatch++;
         $display("Error at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task stop_test;
      $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // each frame waits up to 2010 clk cycles for the engine to go idle before the next one
   task x(input logic [71:0] t, input int nt, nr);
      @(negedge clk);
      h.xfer(q, t, nt, nr, rx);
      repeat (10) @(negedge clk);
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         stop_test();
      end
   end
   initial begin
      repeat (8) @(negedge clk);
      resetn = 1'b1;
      repeat (4) @(negedge clk);
      chk(cfg, srp_pkg::SRP_CFG_RST);
      chk(lk, srp_pkg::SRP_LOCK_RST);
      x({srp_pkg::SRP_OP_CFG_WR, 64'h0}, 24, 0);
      chk(cfg, 16'hffff);
      x(UNL, 8, 0);
      chk(wl, 1'b1);
      x({srp_pkg::SRP_OP_CFG_WR, 64'h0}, 16, 0);
      chk(cfg, 16'hffff);
      $display("test refusals done");
      x(UNL, 8, 0);
      x({srp_pkg::SRP_OP_SEC_WR, 64'h0123456789abcdef}, 72, 0);
      chk(wl, 1'b0);
      x({srp_pkg::SRP_OP_SEC_RD, 64'h0}, 8, 72);
      chk(rx, 64'h23456789abcdef01);
      x(UNL, 8, 0);
      x({srp_pkg::SRP_OP_CFG_WR, 16'hfbff, 48'h0}, 24, 0);
      chk(cfg, 16'hfffb);
      x({srp_pkg::SRP_OP_CFG_RD, 64'h0}, 8, 32);
      chk(rx[31:0], 32'hfbfffbff);
      $display("test programs done");
      x(UNL, 8, 0);
      x({srp_pkg::SRP_OP_LOCK_FRZ, 64'h0}, 9, 0);
      chk(lk, 8'h01);
      x(UNL, 8, 0);
      x({srp_pkg::SRP_OP_LOCK_FRZ, 64'h0}, 8, 0);
      chk(lk, 8'h40);
      q = 1'b1;
      x({srp_pkg::SRP_OP_LOCK_RD, 64'h0}, 8, 16);
      chk(rx[15:0], 16'h4040);
      q = 1'b0;
      x({srp_pkg::SRP_OP_SEC_RD, 64'h0}, 8, 64);
      chk(rx, srp_pkg::SRP_SEC_HIDDEN);
      x(UNL, 8, 0);
      @(negedge clk);
      h.xfer(q, {srp_pkg::SRP_OP_SEC_WR, 64'h0}, 72, 0, rx);
      repeat (8) @(negedge clk);
      chk(busy, 1'b0);
      $display("test lock and secret done");
      x(UNL, 8, 0);
      pf = 1'b1;
      x({srp_pkg::SRP_OP_CFG_WR, 16'hfbff, 48'h0}, 24, 0);
      chk(pe, 1'b1);
      sc = 1'b1;
      @(negedge clk);
      sc = 1'b0;
      repeat (4) @(negedge clk);
      chk(pe, 1'b0);
      $display("test failure done");
      stop_test();
   end
endmodule
